/* File: rtl/cif_pkg.sv */
// Package: constants, types and the address map of the interrupt flag unit
package cif_pkg;

  // ---------------------------------------------------------------------
  // Address space
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam logic [19:0] ADDR_LOW = 20'h00000;
  localparam logic [19:0] ADDR_HIGH = 20'hfffff;
  localparam logic [19:0] PERIPH_LO = 20'h00000;
  localparam logic [19:0] PERIPH_HI = 20'h002ff;
  localparam logic [19:0] RAM_LO = 20'h00400;
  localparam logic [19:0] RAM_HI = 20'h009ff;
  localparam logic [19:0] DFLASH_LO = 20'h02400;
  localparam logic [19:0] DFLASH_HI = 20'h02bff;
  localparam logic [19:0] ROM_LO = 20'h0c000;
  localparam logic [19:0] ROM_HI = 20'h0ffff;
  localparam logic [19:0] VECT_LO = 20'h0ffdc;
  localparam logic [19:0] VECT_HI = 20'h0ffff;

  // ---------------------------------------------------------------------
  // Register offsets on the bus (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFF_FLAGS = 8'h00;
  localparam logic [7:0] OFF_ISTACK = 8'h04;
  localparam logic [7:0] OFF_USTACK = 8'h08;
  localparam logic [7:0] OFF_PC = 8'h0c;
  localparam logic [7:0] OFF_SWI = 8'h10;
  localparam logic [7:0] OFF_DECODE = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // ---------------------------------------------------------------------
  // Flag register fields
  // ---------------------------------------------------------------------
  localparam int BIT_IEN = 6;
  localparam int BIT_SSEL = 7;
  localparam int BIT_RSVD = 5;
  localparam int PPL_LSB = 12;
  localparam int PPL_W = 3;
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [4:0] SWI_STACK_MAX = 5'h1f;
  localparam logic [19:0] STACK_RST = 20'h00a00;
  localparam logic [19:0] PC_RST = 20'h0c000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // Region codes from the decoder
  typedef enum logic [2:0] {
    CIF_REG_NONE, CIF_REG_PERIPH, CIF_REG_RAM, CIF_REG_DFLASH,
    CIF_REG_ROM, CIF_REG_VECT
  } cif_region_type;

  // Interrupt request group
  typedef struct packed {
    logic valid;
    logic [2:0] level;
    logic [4:0] vector;
  } cif_req_type;

  // Stack write output group
  typedef struct packed {
    logic valid;
    logic [19:0] addr;
    logic [15:0] data;
  } cif_stack_wr_type;

endpackage : cif_pkg

/* File: rtl/cif_addr_decode.sv */
// Address map decoder of the 1 Mbyte processor space
`timescale 1ns/1ps
module cif_addr_decode
  import cif_pkg::*;
(
  input wire logic [19:0] addr,
  output cif_region_type region
);

  // Range test used for every region
  function automatic logic in_range(input logic [19:0] a,
                                    input logic [19:0] lo,
                                    input logic [19:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // ---------------------------------------------------------------------
  // Region selection, vector table ahead of the rest of ROM
  // ---------------------------------------------------------------------
  wire logic hit_vect = in_range(addr, VECT_LO, VECT_HI);
  wire logic hit_rom = in_range(addr, ROM_LO, ROM_HI);
  wire logic hit_dfl = in_range(addr, DFLASH_LO, DFLASH_HI);
  wire logic hit_ram = in_range(addr, RAM_LO, RAM_HI);
  wire logic hit_per = in_range(addr, PERIPH_LO, PERIPH_HI);

  assign region = hit_vect ? CIF_REG_VECT :
                  hit_rom ? CIF_REG_ROM :
                  hit_dfl ? CIF_REG_DFLASH :
                  hit_ram ? CIF_REG_RAM :
                  hit_per ? CIF_REG_PERIPH : CIF_REG_NONE;

endmodule : cif_addr_decode

/* File: rtl/cif_flags.sv */
// Interrupt flags, acceptance sequence and address map over AHB-Lite
`timescale 1ns/1ps
module cif_flags
  import cif_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire cif_req_type irq_req,
  input wire logic [19:0] core_addr,
  output logic irq_ack,
  output logic [4:0] irq_ack_vector,
  output cif_stack_wr_type stack_wr,
  output logic [19:0] vector_addr,
  output logic [2:0] core_region
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef enum {ST_IDLE, ST_PUSH_FLAGS, ST_PUSH_PC, ST_VECTOR}
    cif_state_type;

  cif_state_type state;
  cif_state_type next_state;
  logic [15:0] flags;
  logic [PPL_W-1:0] cur_level;
  logic [19:0] interrupt_stack_pointer;
  logic [19:0] user_stack_pointer;
  logic [19:0] pc;
  logic [4:0] cur_vector;
  logic cur_hw;
  logic wr_pend;
  logic [7:0] wr_off;

  // Flag fields
  wire logic ien = flags[BIT_IEN];
  wire logic ssel = flags[BIT_SSEL];
  wire logic [PPL_W-1:0] processor_priority_level =
    flags[PPL_LSB +: PPL_W];

  // ---------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------
  wire logic addr_phase = hsel && hready && htrans[1];
  wire logic do_write = wr_pend;
  wire logic hit_flags = (wr_off == OFF_FLAGS);
  wire logic hit_istack = (wr_off == OFF_ISTACK);
  wire logic hit_ustack = (wr_off == OFF_USTACK);
  wire logic hit_pc = (wr_off == OFF_PC);
  wire logic hit_swi = (wr_off == OFF_SWI);
  wire logic [15:0] wdata16 = hwdata[15:0];
  wire logic [4:0] swi_num = hwdata[4:0];

  // Software interrupt write starts the sequence too
  wire logic swi_go = do_write && hit_swi && (state == ST_IDLE);

  // Request acceptance: enable set and level strictly above current
  wire logic hw_accept = (state == ST_IDLE) && irq_req.valid && ien &&
    (irq_req.level > processor_priority_level) && !swi_go;

  // Sequence start, from either a hardware or a software request
  wire logic seq_start = (state == ST_IDLE) && (hw_accept || swi_go);

  // ---------------------------------------------------------------------
  // Stack pointer arithmetic
  // ---------------------------------------------------------------------
  // One push moves the pointer down by one halfword slot
  localparam logic [19:0] STACK_STEP = 20'h00002;

  // Pointer one slot below the given one
  function automatic logic [19:0] sp_down(input logic [19:0] sp);
    sp_down = sp - STACK_STEP;
  endfunction : sp_down

  // Selected stack pointer and the slots of the two pushes
  wire logic [19:0] sp_sel = ssel ? user_stack_pointer :
    interrupt_stack_pointer;
  wire logic [19:0] sp_dec = sp_down(sp_sel);
  wire logic [19:0] sp_frame = sp_down(sp_dec);

  // ---------------------------------------------------------------------
  // Stack push contents
  // ---------------------------------------------------------------------
  // Flags go one slot below the old top, the return address at the new top
  wire logic push_now = seq_start || (state == ST_PUSH_FLAGS);
  wire logic [19:0] push_addr = seq_start ? sp_dec : sp_sel;
  wire logic [15:0] push_data = seq_start ? flags : pc[15:0];

  // ---------------------------------------------------------------------
  // Flag values written at acceptance
  // ---------------------------------------------------------------------
  // Every software number the field can carry clears stack-select
  wire logic clear_ssel = cur_hw || (cur_vector <= SWI_STACK_MAX);
  wire logic [PPL_W-1:0] next_ppl =
    cur_hw ? cur_level : processor_priority_level;
  wire logic [15:0] flag_wr_mask = ~(16'h0001 << BIT_RSVD);

  // Vector entry address: four bytes per entry from the table base
  wire logic [19:0] vect_entry =
    VECT_LO + {13'h0000, cur_vector, 2'b00};

  // ---------------------------------------------------------------------
  // Address map for core accesses
  // ---------------------------------------------------------------------
  cif_region_type dec_region;

  cif_addr_decode u_decode (
    .addr(core_addr),
    .region(dec_region)
  );

  // ---------------------------------------------------------------------
  // Read mux for bus registers
  // ---------------------------------------------------------------------
  wire logic [7:0] rd_off = haddr[7:0];
  wire logic [31:0] rd_value =
    (rd_off == OFF_FLAGS) ? {16'h0000, flags} :
    (rd_off == OFF_ISTACK) ? {12'h000, interrupt_stack_pointer} :
    (rd_off == OFF_USTACK) ? {12'h000, user_stack_pointer} :
    (rd_off == OFF_PC) ? {12'h000, pc} :
    (rd_off == OFF_DECODE) ? {29'h0, dec_region} :
    (rd_off == OFF_STATUS) ? {30'h0, state != ST_IDLE, ien} :
    UNMAPPED_READ;

  // ---------------------------------------------------------------------
  // Sequencer next state
  // ---------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (hw_accept || swi_go) begin
          next_state = ST_PUSH_FLAGS;
        end
      end
      ST_PUSH_FLAGS: begin
        next_state = ST_PUSH_PC;
      end
      ST_PUSH_PC: begin
        next_state = ST_VECTOR;
      end
      ST_VECTOR: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Bus data phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_off <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend <= addr_phase && hwrite;
      wr_off <= haddr[7:0];
      if (addr_phase && !hwrite) begin
        hrdata <= rd_value;
      end
    end
  end

  // Bus answers zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Sequence state and entry capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      cur_vector <= 5'h00;
      cur_hw <= 1'b0;
      cur_level <= '0;
    end else begin
      state <= next_state;
      if (hw_accept) begin
        cur_vector <= irq_req.vector;
        cur_hw <= 1'b1;
        cur_level <= irq_req.level;
      end else if (swi_go) begin
        cur_vector <= swi_num;
        cur_hw <= 1'b0;
        cur_level <= processor_priority_level;
      end
    end
  end

  // Flags: software writes; enable and stack-select cleared, level loaded at acceptance after the save
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= FLAGS_RST;
    end else if (state == ST_PUSH_FLAGS) begin
      flags[BIT_IEN] <= 1'b0;
      if (clear_ssel) begin
        flags[BIT_SSEL] <= 1'b0;
      end
      flags[PPL_LSB +: PPL_W] <= next_ppl;
    end else if (do_write && hit_flags) begin
      flags <= wdata16 & flag_wr_mask;
    end
  end

  // Stack pointers and program counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_stack_pointer <= STACK_RST;
      user_stack_pointer <= STACK_RST;
      pc <= PC_RST;
    end else if (seq_start) begin
      // Room for both pushes is taken at once
      if (ssel) begin
        user_stack_pointer <= sp_frame;
      end else begin
        interrupt_stack_pointer <= sp_frame;
      end
    end else if (state == ST_VECTOR) begin
      pc <= vect_entry;
    end else begin
      if (do_write && hit_istack) begin
        interrupt_stack_pointer <= hwdata[19:0];
      end
      if (do_write && hit_ustack) begin
        user_stack_pointer <= hwdata[19:0];
      end
      if (do_write && hit_pc) begin
        pc <= hwdata[19:0];
      end
    end
  end

  // Stack pushes into RAM and acknowledge outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stack_wr <= '0;
      irq_ack <= 1'b0;
      irq_ack_vector <= 5'h00;
      vector_addr <= VECT_LO;
      core_region <= 3'h0;
    end else begin
      stack_wr.valid <= 1'b0;
      irq_ack <= hw_accept;
      core_region <= dec_region;
      if (hw_accept) begin
        irq_ack_vector <= irq_req.vector;
      end
      if (push_now) begin
        stack_wr.valid <= 1'b1;
        stack_wr.addr <= push_addr;
        stack_wr.data <= push_data;
      end
      if (state == ST_PUSH_PC) begin
        vector_addr <= vect_entry;
      end
    end
  end

endmodule : cif_flags

/* File: bench/cif_checker.sv */
// Port checker of the interrupt flag unit
`timescale 1ns/1ps
module cif_checker
  import cif_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire cif_req_type irq_req,
  input wire logic [19:0] core_addr,
  input wire logic irq_ack,
  input wire logic [4:0] irq_ack_vector,
  input wire cif_stack_wr_type stack_wr,
  input wire logic [19:0] vector_addr,
  input wire logic [2:0] core_region
);
  // ------------------------------------------------------------
  // Port relations
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  AST_ACK_PULSE: assert property (irq_ack |=> !irq_ack)
    else $error("acknowledge longer than one cycle");
  AST_ACK_CAUSE: assert property (irq_ack |-> $past(irq_req.valid)
    && irq_ack_vector == $past(irq_req.vector))
    else $error("acknowledge without matching request");
  AST_PUSH: assert property (irq_ack |-> stack_wr.valid
    ##1 stack_wr.valid ##1 !stack_wr.valid)
    else $error("flags and pc not pushed in order");
  AST_PUSH_RAM: assert property (stack_wr.valid
    |-> stack_wr.addr inside {[RAM_LO:RAM_HI]})
    else $error("stack write outside ram");
  AST_VECTOR: assert property (irq_ack |-> ##2
    vector_addr == VECT_LO + {irq_ack_vector, 2'h0})
    else $error("wrong vector entry address");
  AST_RGN_PERIPH: assert property ($past(hresetn)
    && $past(core_addr) <= PERIPH_HI |-> core_region == CIF_REG_PERIPH)
    else $error("peripheral space decode");
  AST_RGN_RAM: assert property ($past(hresetn)
    && $past(core_addr) inside {[RAM_LO:RAM_HI]}
    |-> core_region == CIF_REG_RAM)
    else $error("ram decode");
  AST_RGN_DFLASH: assert property ($past(hresetn)
    && $past(core_addr) inside {[DFLASH_LO:DFLASH_HI]}
    |-> core_region == CIF_REG_DFLASH)
    else $error("data flash decode");
  AST_RGN_ROM: assert property ($past(hresetn)
    && $past(core_addr) >= ROM_LO && $past(core_addr) < VECT_LO
    |-> core_region == CIF_REG_ROM)
    else $error("rom decode");
  AST_RGN_VECT: assert property ($past(hresetn)
    && $past(core_addr) inside {[VECT_LO:VECT_HI]}
    |-> core_region == CIF_REG_VECT)
    else $error("vector table decode");
  AST_RGN_HIGH: assert property ($past(hresetn)
    && $past(core_addr) > ROM_HI |-> core_region == CIF_REG_NONE)
    else $error("upper space decode");
endmodule : cif_checker

/* File: bench/cif_irq_src.sv */
// Interrupt source model holding its request until acknowledged or cancelled
`timescale 1ns/1ps
module cif_irq_src
  import cif_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic cancel,
  input wire logic [2:0] level,
  input wire logic [4:0] vector,
  input wire logic irq_ack,
  output cif_req_type irq_req
);
  // Held request; idle fields flip so stale values never match
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_req <= '0;
    end else if (start) begin
      irq_req <= {1'b1, level, vector};
    end else if (irq_ack || cancel) begin
      irq_req <= {1'b0, ~irq_req.level, ~irq_req.vector};
    end
  end
endmodule : cif_irq_src

/* File: bench/tb_top.sv */
// Testbench of the interrupt flag unit
`timescale 1ns/1ps
module tb_top
  import cif_pkg::*;
();
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq_ack;
  logic s_start, s_cancel, got_ack;
  logic [1:0] htrans;
  logic [2:0] hsize, core_region, s_lvl;
  logic [4:0] irq_ack_vector, s_vec;
  logic [19:0] core_addr, vector_addr;
  logic [31:0] haddr, hwdata, hrdata, rd;
  cif_req_type irq_req;
  cif_stack_wr_type stack_wr, sw_cap, pc_cap;
  int n_errors, compares;
  // Region code above address
  logic [22:0] map [15] = '{23'h100000, 23'h1002ff, 23'h000300,
    23'h200400, 23'h2009ff, 23'h000a00, 23'h302400, 23'h302bff,
    23'h002c00, 23'h40c000, 23'h40ffdb, 23'h50ffdc, 23'h50ffff,
    23'h010000, 23'h0fffff};

  cif_flags u_cif_flags (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .irq_req, .core_addr, .irq_ack, .irq_ack_vector, .stack_wr,
    .vector_addr, .core_region);
  cif_irq_src u_cif_irq_src (.hclk, .hresetn, .start(s_start),
    .cancel(s_cancel), .level(s_lvl), .vector(s_vec), .irq_ack, .irq_req);

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One single word transfer, waits on ready in both phases
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  // Raise a request, capture the push at acknowledge, drop if refused
  task automatic req(input logic [2:0] l, input logic [4:0] v);
    @(posedge hclk);
    s_lvl <= l;
    s_vec <= v;
    s_start <= 1'b1;
    @(posedge hclk);
    s_start <= 1'b0;
    got_ack = 1'b0;
    for (int i = 0; i < 12 && !got_ack; i++) begin
      @(posedge hclk);
      got_ack = (irq_ack === 1'b1);
      sw_cap = stack_wr;
    end
    s_cancel <= !got_ack;
    @(posedge hclk);
    pc_cap = stack_wr;
    s_cancel <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask : req

  task automatic final_report();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // ------------------------------------------------------------
  // Clock, watchdog and tests
  // ------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Tests need about 200 cycles; allow well over ten times that
  initial begin
    #50000;
    n_errors++;
    final_report();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    core_addr = 20'h0;
    s_start = 1'b0;
    s_cancel = 1'b0;
    s_lvl = 3'h0;
    s_vec = 5'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(OFF_PC, 32'h0000c000);
    ahb(1'b1, 8'h1c, 32'hffffffff);
    rdc(8'h1c, 32'h0);
    rdc(OFF_FLAGS, 32'h0);
    $display("test reset and unmapped done");
    req(3'h7, 5'h5);
    chk({31'h0, got_ack}, 32'h0);
    ahb(1'b1, OFF_USTACK, 32'h00000900);
    ahb(1'b1, OFF_FLAGS, 32'h000030c0);
    req(3'h3, 5'h5);
    chk({31'h0, got_ack}, 32'h0);
    req(3'h4, 5'h5);
    chk({31'h0, got_ack}, 32'h1);
    chk({16'h0, sw_cap.data}, 32'h000030c0);
    chk({12'h0, sw_cap.addr}, 32'h000008fe);
    chk({12'h0, pc_cap.addr}, 32'h000008fc);
    chk({16'h0, pc_cap.data}, 32'h0000c000);
    chk({12'h0, vector_addr}, 32'h0000fff0);
    rdc(OFF_FLAGS, 32'h00004000);
    rdc(OFF_PC, 32'h0000fff0);
    rdc(OFF_ISTACK, 32'h00000a00);
    rdc(OFF_USTACK, 32'h000008fc);
    ahb(1'b1, OFF_FLAGS, 32'h00007040);
    rdc(OFF_STATUS, 32'h00000001);
    req(3'h7, 5'h1);
    chk({31'h0, got_ack}, 32'h0);
    $display("test acceptance done");
    ahb(1'b1, OFF_FLAGS, 32'h000050c0);
    ahb(1'b1, OFF_SWI, 32'h0000001f);
    repeat (6) @(posedge hclk);
    rdc(OFF_FLAGS, 32'h00005000);
    $display("test software interrupt done");
    // Core addresses are only classified, never accessed
    for (int i = 0; i < 15; i++) begin
      core_addr <= map[i][19:0];
      repeat (2) @(posedge hclk);
      chk({29'h0, core_region}, {29'h0, map[i][22:20]});
      rdc(OFF_DECODE, {29'h0, map[i][22:20]});
    end
    $display("test address map done");
    final_report();
  end
endmodule : tb_top

bind cif_flags cif_checker u_cif_checker (.hclk, .hresetn, .hreadyout,
  .hresp, .irq_req, .core_addr, .irq_ack, .irq_ack_vector, .stack_wr,
  .vector_addr, .core_region);
